//--- rtl/scs_pkg.sv
// Package with the register map, field positions and timing constants of the serial port.
package scs_pkg;

  // Register addresses on the special function register port.
  localparam logic [7:0] CFG_ADDR  = 8'ha1;
  localparam logic [7:0] DATA_ADDR = 8'ha3;

  // Field positions in the configuration and status register.
  localparam int BUSY_BIT = 7;
  localparam int MSTR_BIT = 6;
  localparam int CPHA_BIT = 5;
  localparam int CPOL_BIT = 4;
  localparam int SEL_BIT  = 3;
  localparam int PIN_BIT  = 2;
  localparam int SHIFTER_EMPTY_BIT = 1;
  localparam int RXE_BIT  = 0;

  // Value that the configuration and status register shows after reset.
  localparam logic [7:0] CFG_RESET = 8'h07;
  localparam logic [7:0] RD_ZERO   = 8'h00;

  // Master bit period: the shortest bit time rounded up to whole clocks.
  localparam int CLK_PERIOD_NS = 10;
  localparam int MIN_BIT_NS    = 80;
  localparam int BIT_CYC       = (MIN_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HALF_CYC      = BIT_CYC / 2;
  localparam logic [2:0] CNT_ZERO   = 3'h0;
  localparam logic [2:0] CNT_LAST   = 3'(BIT_CYC - 1);
  localparam logic [2:0] CNT_SAMPLE = 3'(BIT_CYC - 2);
  localparam logic [2:0] CNT_HALF   = 3'(HALF_CYC);
  localparam logic [2:0] BIT_LAST   = 3'h7;

  // Data path sizes.
  localparam int BYTE_W     = 8;
  localparam int FIFO_DEPTH = 16;

  // Synchroniser reset levels: select idles high, clock, data in and data out idle low.
  localparam logic [3:0] SYNC_RESET = 4'h8;

  // Serial clock level for a master bit counter position; an idle port holds the polarity level.
  function automatic logic sck_level(input logic run, input logic [2:0] cnt, input logic cpha,
                                     input logic cpol);
    logic active;
    active = cpha ? (cnt < CNT_HALF) : (cnt >= CNT_HALF);
    return run ? (cpol ^ active) : cpol;
  endfunction

  typedef enum logic [0:0] {SCS_IDLE, SCS_RUN} scs_mst_state_t;

endpackage

//--- rtl/scs_sync.sv
// Two flip-flop synchroniser for pins that arrive from outside the clock domain.
`timescale 1ns/1ps
module scs_sync #(
  parameter int           W       = 4,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         mclk_in,
  input  wire logic         sys_rst_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // The first stage feeds only the second stage.
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule

//--- rtl/scs_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module scs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             mclk_in,
  input  wire logic             sys_rst_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    wr_d;
  logic [AW-1:0]    rd_q;
  logic [AW-1:0]    rd_d;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             push;
  logic             pop;

  // Pointers wrap at the depth; the count keeps full and empty honest.
  always_comb begin
    push = in_valid_in && (cnt_q != (AW + 1)'(DEPTH));
    pop  = out_ready_in && (cnt_q != '0);
    wr_d = push ? ((wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1) : wr_q;
    rd_d = pop ? ((rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1) : rd_q;
    cnt_d = cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage has no reset so it can map onto plain memory.
  always_ff @(posedge mclk_in) begin
    if (push) begin
      mem_q[wr_q] <= in_data_in;
    end
  end

  assign in_ready_out  = (cnt_q != (AW + 1)'(DEPTH));
  assign out_valid_out = (cnt_q != '0);
  assign out_data_out  = mem_q[rd_q];

endmodule

//--- rtl/scs_cfg_status.sv
// Serial port configuration and status register with its shift engine for master and slave roles.
// Overview of operation
// RULE_01 - Busy bit reads one while a serial transfer runs, master or slave.
// RULE_02 - Master enable bit: zero selects slave role, one selects master role.
// RULE_03 - Clock phase bit: data centred on first edge when zero, second when one.
// RULE_04 - Clock polarity bit: serial clock idles low when zero, high when one.
// RULE_05 - Selected flag is one while de-glitched select is low, zero while high.
// RULE_06 - A read returns the unfiltered select pin level in its own bit.
// RULE_07 - Slave shift-empty sets once shifter, transmit and receive hand-offs are idle.
// RULE_08 - Shift-empty clears on transmit load into shifter or any serial clock transition; code counts clock transitions only while enabled, slave and selected.
// RULE_09 - Shift-empty always reads one in master role.
// RULE_10 - Receive-empty reads zero while an unread byte waits, otherwise one.
// RULE_11 - Receive-empty always reads one in master role.
// RULE_12 - Slave samples incoming data at the middle of each bit.
// RULE_13 - Master samples incoming data one clock before each bit period ends.
// RULE_14 - After reset the register reads with its three lowest bits set.
// RULE_15 - Outside master holds select low to enable; its falling edge clears bit count.
// RULE_16 - Select passes two clock flip-flops before the flag and enable logic see it.
`timescale 1ns/1ps
module scs_cfg_status (
  input  wire logic                      mclk_in,
  input  wire logic                      sys_rst_in,
  input  wire logic [7:0]                sfr_addr_in,
  input  wire logic                      sfr_wr_in,
  input  wire logic                      sfr_rd_in,
  input  wire logic [scs_pkg::BYTE_W-1:0] sfr_wdata_in,
  output logic      [scs_pkg::BYTE_W-1:0] sfr_rdata_out,
  input  wire logic                      spi_enable_in,
  input  wire logic                      slave_select_n_in,
  input  wire logic                      sck_pin_in,
  output logic                           sck_out,
  output logic                           sck_oe_out,
  input  wire logic                      mosi_pin_in,
  output logic                           mosi_out,
  output logic                           mosi_oe_out,
  input  wire logic                      miso_pin_in,
  output logic                           miso_out,
  output logic                           miso_oe_out
);
  import scs_pkg::*;

  logic [3:0]        syn;
  logic              syn_nss;
  logic              syn_sck;
  logic              syn_mosi;
  logic              syn_miso;
  logic              fifo_in_ready;
  logic              fifo_out_valid;
  logic [BYTE_W-1:0] fifo_out_data;

  // Configuration bits written by software.
  logic master_q, master_d, cpha_q, cpha_d, cpol_q, cpol_d;
  // Select filter state.
  logic nss_prev_q, nss_prev_d, nss_filt_q, nss_filt_d;
  // Shift engine state.
  scs_mst_state_t    m_state_q, m_state_d;
  logic [2:0]        cnt_q, cnt_d, bitcnt_q, bitcnt_d;
  logic [BYTE_W-1:0] sh_q, sh_d, tx_buf_q, tx_buf_d, rx_hold_q, rx_hold_d;
  logic              sh_loaded_q, sh_loaded_d, tx_full_q, tx_full_d, rx_pend_q, rx_pend_d;
  logic              shifter_empty_q, shifter_empty_d, sck_prev_q, sck_prev_d, busy_q, busy_d;
  // Registered pin and bus outputs.
  logic              sck_q, sck_d, sck_oe_q, sck_oe_d, mosi_q, mosi_d, mosi_oe_q, mosi_oe_d;
  logic              miso_q, miso_d, miso_oe_q, miso_oe_d;
  logic [BYTE_W-1:0] rdata_q, rdata_d, status_w;
  // Decoded events.
  logic wr_cfg, wr_dat, rd_cfg, rd_dat, slave_act, sck_edge, samp_s, samp_m, samp, in_bit, tx_load;

  // All pins pass two flip-flops before any logic reads them.
  scs_sync #(.W(4), .RST_VAL(SYNC_RESET)) u_sync (
    .mclk_in    (mclk_in),
    .sys_rst_in (sys_rst_in),
    .async_in   ({slave_select_n_in, sck_pin_in, mosi_pin_in, miso_pin_in}),
    .sync_out   (syn)
  );
  assign syn_nss  = syn[3]; // [RULE_16]
  assign syn_sck  = syn[2];
  assign syn_mosi = syn[1];
  assign syn_miso = syn[0];

  // Received bytes queue here; a full queue holds the next byte back in the pending stage.
  scs_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .mclk_in       (mclk_in),
    .sys_rst_in    (sys_rst_in),
    .in_valid_in   (rx_pend_q),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (rx_hold_q),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (rd_dat),
    .out_data_out  (fifo_out_data)
  );

  // Status view of the register; master role forces both empty flags high.
  always_comb begin
    status_w           = RD_ZERO;
    status_w[BUSY_BIT] = busy_q;                         // [RULE_01]
    status_w[MSTR_BIT] = master_q;
    status_w[CPHA_BIT] = cpha_q;
    status_w[CPOL_BIT] = cpol_q;
    status_w[SEL_BIT]  = ~nss_filt_q;                    // [RULE_05]
    status_w[PIN_BIT]  = syn_nss;                        // [RULE_06]
    status_w[SHIFTER_EMPTY_BIT] = master_q | shifter_empty_q;              // [RULE_09]
    status_w[RXE_BIT]  = master_q | ~fifo_out_valid;     // [RULE_10] [RULE_11]
  end

  // Register port decode, configuration writes, read data and select filter.
  always_comb begin
    wr_cfg   = sfr_wr_in && (sfr_addr_in == CFG_ADDR);
    wr_dat   = sfr_wr_in && (sfr_addr_in == DATA_ADDR);
    rd_cfg   = sfr_rd_in && (sfr_addr_in == CFG_ADDR);
    rd_dat   = sfr_rd_in && (sfr_addr_in == DATA_ADDR);
    master_d = wr_cfg ? sfr_wdata_in[MSTR_BIT] : master_q; // [RULE_02]
    cpha_d   = wr_cfg ? sfr_wdata_in[CPHA_BIT] : cpha_q;
    cpol_d   = wr_cfg ? sfr_wdata_in[CPOL_BIT] : cpol_q;
    // A new select level is taken only after two agreeing synchronised samples.
    nss_prev_d = syn_nss;
    nss_filt_d = (syn_nss == nss_prev_q) ? syn_nss : nss_filt_q; // [RULE_05]
    // Unmapped reads answer zero; the last answer holds between reads.
    rdata_d = rdata_q;
    if (sfr_rd_in) begin
      rdata_d = rd_cfg ? status_w : (rd_dat ? fifo_out_data : RD_ZERO);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      master_q   <= CFG_RESET[MSTR_BIT]; // [RULE_14]
      cpha_q     <= CFG_RESET[CPHA_BIT];
      cpol_q     <= CFG_RESET[CPOL_BIT];
      nss_prev_q <= CFG_RESET[PIN_BIT];
      nss_filt_q <= CFG_RESET[PIN_BIT];
      rdata_q    <= RD_ZERO;
    end else begin
      master_q   <= master_d;
      cpha_q     <= cpha_d;
      cpol_q     <= cpol_d;
      nss_prev_q <= nss_prev_d;
      nss_filt_q <= nss_filt_d;
      rdata_q    <= rdata_d;
    end
  end

  // Shift engine for both roles. Bits shift at the sampling point; the far end has already
  // latched the outgoing bit by then, and the new bit settles well before its own sample.
  always_comb begin
    m_state_d   = m_state_q;
    cnt_d       = cnt_q;
    bitcnt_d    = bitcnt_q;
    sh_d        = sh_q;
    tx_buf_d    = tx_buf_q;
    rx_hold_d   = rx_hold_q;
    sh_loaded_d = sh_loaded_q;
    tx_full_d   = tx_full_q;
    rx_pend_d   = rx_pend_q;
    tx_load     = 1'b0;
    slave_act   = spi_enable_in && !master_q && !nss_filt_q;
    sck_prev_d  = syn_sck;
    sck_edge    = slave_act && (syn_sck != sck_prev_q);
    // Sample on the leading edge for phase zero and on the trailing edge for phase one.
    samp_s      = sck_edge && ((syn_sck != cpol_q) != cpha_q);             // [RULE_12] [RULE_03]
    samp_m      = (m_state_q == SCS_RUN) && (cnt_q == CNT_SAMPLE);         // [RULE_13]
    samp        = samp_s || samp_m;
    in_bit      = master_q ? syn_miso : syn_mosi;
    // The pending byte moves into the queue as soon as the queue has room.
    if (rx_pend_q && fifo_in_ready) begin
      rx_pend_d = 1'b0;
    end
    if (samp) begin
      sh_d     = {sh_q[BYTE_W-2:0], in_bit};
      bitcnt_d = bitcnt_q + 3'h1;
      if (bitcnt_q == BIT_LAST) begin
        sh_loaded_d = 1'b0;
        if (!rx_pend_d) begin
          rx_pend_d = 1'b1;
          rx_hold_d = {sh_q[BYTE_W-2:0], in_bit};
        end
      end
    end
    // Writes to a full transmit buffer are dropped.
    if (wr_dat && !tx_full_q) begin
      tx_buf_d  = sfr_wdata_in;
      tx_full_d = 1'b1;
    end
    if (tx_full_q && !sh_loaded_d && (bitcnt_d == CNT_ZERO)) begin
      sh_d        = tx_buf_q;
      sh_loaded_d = 1'b1;
      tx_full_d   = wr_dat;
      tx_load     = 1'b1;
    end
    // A falling select edge in slave role or a disabled port restarts the bit count.
    if ((nss_filt_q && !nss_filt_d && !master_q) || !spi_enable_in) begin // [RULE_15]
      bitcnt_d = CNT_ZERO;
    end
    // Master sequencer: one bit period is BIT_CYC clocks, back to back while data remains.
    case (m_state_q)
      SCS_IDLE: begin
        cnt_d = CNT_ZERO;
        if (master_q && spi_enable_in && sh_loaded_q) begin
          m_state_d = SCS_RUN;
          bitcnt_d  = CNT_ZERO;
        end
      end
      SCS_RUN: begin
        cnt_d = cnt_q + 3'h1;
        if (cnt_q == CNT_LAST) begin
          cnt_d = CNT_ZERO;
          if ((bitcnt_q == CNT_ZERO && !sh_loaded_q) || !master_q || !spi_enable_in) begin
            m_state_d = SCS_IDLE;
          end
        end
      end
      default: begin
        m_state_d = SCS_IDLE;
      end
    endcase
    // Shift-empty: set when nothing waits anywhere and the clock rests; cleared by a load or edge.
    shifter_empty_d = shifter_empty_q;
    if (tx_load || sck_edge) begin
      shifter_empty_d = 1'b0;                                                        // [RULE_08]
    end else if (!sh_loaded_q && !tx_full_q && !rx_pend_q && (bitcnt_q == CNT_ZERO)
                 && (syn_sck == cpol_q)) begin
      shifter_empty_d = 1'b1;                                                        // [RULE_07]
    end
    busy_d    = (m_state_d == SCS_RUN) || (slave_act && ((bitcnt_d != CNT_ZERO) || (syn_sck != cpol_q))); // [RULE_01]
    sck_d     = sck_level(m_state_d == SCS_RUN, cnt_d, cpha_q, cpol_q);    // [RULE_03] [RULE_04]
    sck_oe_d  = master_q && spi_enable_in;                                  // [RULE_02]
    mosi_d    = sh_d[BYTE_W-1];
    mosi_oe_d = master_q && spi_enable_in;
    miso_d    = sh_d[BYTE_W-1];
    miso_oe_d = spi_enable_in && !master_q && !nss_filt_d;
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      m_state_q   <= SCS_IDLE;
      cnt_q       <= CNT_ZERO;
      bitcnt_q    <= CNT_ZERO;
      sh_q        <= RD_ZERO;
      tx_buf_q    <= RD_ZERO;
      rx_hold_q   <= RD_ZERO;
      sh_loaded_q <= 1'b0;
      tx_full_q   <= 1'b0;
      rx_pend_q   <= 1'b0;
      shifter_empty_q      <= CFG_RESET[SHIFTER_EMPTY_BIT];
      sck_prev_q  <= 1'b0;
      busy_q      <= CFG_RESET[BUSY_BIT];
      sck_q       <= 1'b0;
      sck_oe_q    <= 1'b0;
      mosi_q      <= 1'b0;
      mosi_oe_q   <= 1'b0;
      miso_q      <= 1'b0;
      miso_oe_q   <= 1'b0;
    end else begin
      m_state_q   <= m_state_d;
      cnt_q       <= cnt_d;
      bitcnt_q    <= bitcnt_d;
      sh_q        <= sh_d;
      tx_buf_q    <= tx_buf_d;
      rx_hold_q   <= rx_hold_d;
      sh_loaded_q <= sh_loaded_d;
      tx_full_q   <= tx_full_d;
      rx_pend_q   <= rx_pend_d;
      shifter_empty_q      <= shifter_empty_d;
      sck_prev_q  <= sck_prev_d;
      busy_q      <= busy_d;
      sck_q       <= sck_d;
      sck_oe_q    <= sck_oe_d;
      mosi_q      <= mosi_d;
      mosi_oe_q   <= mosi_oe_d;
      miso_q      <= miso_d;
      miso_oe_q   <= miso_oe_d;
    end
  end

  assign sfr_rdata_out = rdata_q;
  assign sck_out       = sck_q;
  assign sck_oe_out    = sck_oe_q;
  assign mosi_out      = mosi_q;
  assign mosi_oe_out   = mosi_oe_q;
  assign miso_out      = miso_q;
  assign miso_oe_out   = miso_oe_q;

  // Checks on the behaviour above.
  sequence s_cfg_read;
    sfr_rd_in && (sfr_addr_in == CFG_ADDR);
  endsequence
  sequence s_master_start;
    (m_state_q == SCS_IDLE) && (m_state_d == SCS_RUN);
  endsequence
  property p_reset_value;
    @(posedge mclk_in) sys_rst_in |=> (status_w == CFG_RESET);
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("Register not at reset value."); // [RULE_14]
  property p_busy_master;
    @(posedge mclk_in) disable iff (sys_rst_in) s_master_start |=> busy_q [*8];
  endproperty
  a_busy_master: assert property (p_busy_master) else $error("Busy low during master byte."); // [RULE_01]
  property p_master_flags;
    @(posedge mclk_in) disable iff (sys_rst_in)
      (sfr_rd_in && (sfr_addr_in == CFG_ADDR) && master_q)
      |=> (sfr_rdata_out[1:0] == 2'h3) && sfr_rdata_out[MSTR_BIT];
  endproperty
  a_master_flags: assert property (p_master_flags) else $error("Empty flags not forced in master."); // [RULE_09]
  property p_sck_idle;
    @(posedge mclk_in) disable iff (sys_rst_in)
      ((m_state_q == SCS_IDLE) && (m_state_d == SCS_IDLE)) |=> (sck_out == $past(cpol_q));
  endproperty
  a_sck_idle: assert property (p_sck_idle) else $error("Serial clock not at idle level."); // [RULE_04]
  property p_phase_mid;
    @(posedge mclk_in) disable iff (sys_rst_in)
      ((m_state_q == SCS_RUN) && (cnt_q == CNT_HALF)) |-> ((sck_out != cpol_q) == !cpha_q);
  endproperty
  a_phase_mid: assert property (p_phase_mid) else $error("Clock phase wrong at mid bit."); // [RULE_03]
  property p_selected;
    @(posedge mclk_in) disable iff (sys_rst_in) (!syn_nss) [*2] |=> status_w[SEL_BIT];
  endproperty
  a_selected: assert property (p_selected) else $error("Selected flag not set."); // [RULE_05]
  property p_pin_raw;
    @(posedge mclk_in) disable iff (sys_rst_in) s_cfg_read |=> (sfr_rdata_out[PIN_BIT] == $past(syn_nss));
  endproperty
  a_pin_raw: assert property (p_pin_raw) else $error("Select pin bit wrong."); // [RULE_06]
  property p_shifter_empty_fall;
    @(posedge mclk_in) disable iff (sys_rst_in) (sck_edge || tx_load) |=> !shifter_empty_q;
  endproperty
  a_shifter_empty_fall: assert property (p_shifter_empty_fall) else $error("Shift-empty did not clear."); // [RULE_08]
  property p_rx_empty;
    @(posedge mclk_in) disable iff (sys_rst_in)
      (sfr_rd_in && (sfr_addr_in == CFG_ADDR) && !master_q && fifo_out_valid) |=> !sfr_rdata_out[RXE_BIT];
  endproperty
  a_rx_empty: assert property (p_rx_empty) else $error("Receive-empty set with data waiting."); // [RULE_10]
  // A transmit load on the last sample replaces the shifter, so that cycle is left out.
  property p_master_sample;
    @(posedge mclk_in) disable iff (sys_rst_in) (samp_m && !tx_load) |=> (sh_q[0] == $past(syn_miso));
  endproperty
  a_master_sample: assert property (p_master_sample) else $error("Master sample not taken."); // [RULE_13]
  property p_slave_sample;
    @(posedge mclk_in) disable iff (sys_rst_in) (samp_s && !tx_load) |=> (sh_q[0] == $past(syn_mosi));
  endproperty
  a_slave_sample: assert property (p_slave_sample) else $error("Slave sample not taken."); // [RULE_12]

endmodule

//--- tb/scs_far_end.sv
// Behavioural far-end serial device: slave to the block in master role, master to it in slave role.
`timescale 1ns/1ps
module scs_far_end (
  input  wire logic mclk_in,
  input  wire logic sck_in,
  input  wire logic mosi_in,
  input  wire logic miso_in,
  output logic      sck_drv_out,
  output logic      mosi_drv_out,
  output logic      miso_drv_out,
  output logic      sel_n_out
);
  logic       cpol_q = 1'h0, cpha_q = 1'h0, mst_q = 1'h0, frame_q = 1'h0, mosi_q = 1'h0, flip_q = 1'h0;
  logic [7:0] tx_q   = 8'h00;
  logic [7:0] rx_q   = 8'h00;
  int         edges  = 0;
  int         idx;
  // Undriven lines toggle every clock, so a stale level can never pass for data.
  always @(posedge mclk_in) flip_q <= ~flip_q;
  // Sample on the edge that the phase setting names, most significant bit first.
  always @(sck_in) begin
    if ((sck_in != cpol_q) != cpha_q) rx_q = {rx_q[6:0], mst_q ? miso_in : mosi_in};
    edges++;
  end
  // As slave, the next bit is launched on the edge opposite the sample edge.
  always_comb begin
    idx = cpha_q ? (edges == 0 ? 0 : (edges - 1) / 2) : edges / 2;
    if (idx > 7) idx = 7;
  end
  assign miso_drv_out = mst_q ? flip_q : tx_q[7 - idx];
  assign mosi_drv_out = frame_q ? mosi_q : flip_q;
  initial begin
    sck_drv_out = 1'h0;
    sel_n_out = 1'h1;
  end
  // Loads mode, role and outgoing byte; the serial clock parks at its idle level.
  task automatic arm(input logic pol, input logic pha, input logic mst, input logic [7:0] tx);
    cpol_q = pol;
    cpha_q = pha;
    mst_q = mst;
    tx_q = tx;
    rx_q = 8'h00;
    edges = 0;
    sck_drv_out = pol;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  // Plays the bus master at 16 clocks a bit, well under the slave's rate limit.
  task automatic xfer();
    edges = 0;
    rx_q = 8'h00;
    sel_n_out = 1'h0;
    frame_q = 1'h1;
    step(8);
    for (int i = 7; i >= 0; i--) begin
      if (cpha_q) sck_drv_out = ~cpol_q;
      mosi_q = tx_q[i];
      step(8);
      sck_drv_out = cpha_q ? cpol_q : ~cpol_q;
      step(8);
      if (!cpha_q) sck_drv_out = cpol_q;
    end
    step(8);
    frame_q = 1'h0;
    sel_n_out = 1'h1;
  endtask
endmodule

//--- tb/tb.sv
// Self-checking bench for the serial port configuration and status register.
`timescale 1ns/1ps
module tb;
  import scs_pkg::*;
  logic        mclk_in = 1'h0, sys_rst_in = 1'h1, sfr_wr_in = 1'h0, sfr_rd_in = 1'h0, spi_enable_in = 1'h1;
  logic [7:0]  sfr_addr_in = 8'h00, sfr_wdata_in = 8'h00, sfr_rdata_out;
  logic        sck_out, sck_oe_out, mosi_out, mosi_oe_out, miso_out, miso_oe_out, rd_seen, pol, pha;
  logic        far_sck, far_mosi, far_miso, far_sel_n;
  logic [7:0]  txb, fb;
  logic [7:0]  fill [17];
  logic [15:0] ent;
  logic [15:0] exp_q [$];
  int          err_total = 0, total_checks = 0;
  wire         sck_w  = sck_oe_out ? sck_out : far_sck;
  wire         mosi_w = mosi_oe_out ? mosi_out : far_mosi;
  wire         miso_w = miso_oe_out ? miso_out : far_miso;

  scs_cfg_status dut_u (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .sfr_addr_in(sfr_addr_in),
    .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in), .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
    .spi_enable_in(spi_enable_in), .slave_select_n_in(far_sel_n), .sck_pin_in(sck_w), .sck_out(sck_out),
    .sck_oe_out(sck_oe_out), .mosi_pin_in(mosi_w), .mosi_out(mosi_out), .mosi_oe_out(mosi_oe_out),
    .miso_pin_in(miso_w), .miso_out(miso_out), .miso_oe_out(miso_oe_out));
  scs_far_end far_u (.mclk_in(mclk_in), .sck_in(sck_w), .mosi_in(mosi_w), .miso_in(miso_w),
    .sck_drv_out(far_sck), .mosi_drv_out(far_mosi), .miso_drv_out(far_miso), .sel_n_out(far_sel_n));

  // Free-running 100 MHz clock.
  initial forever #5 mclk_in = ~mclk_in;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask
  // Strobes drop for a cycle between accesses so no signal is driven twice in one step.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    sfr_addr_in = a;
    sfr_wdata_in = d;
    sfr_wr_in = 1'h1;
    cyc(1);
    sfr_wr_in = 1'h0;
    cyc(1);
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    sfr_addr_in = a;
    sfr_rd_in = 1'h1;
    exp_q.push_back({m, e});
    cyc(1);
    sfr_rd_in = 1'h0;
    cyc(1);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Read data lands one edge after the strobe; compare it against the oldest note at mid-cycle.
  always @(posedge mclk_in) rd_seen <= sfr_rd_in;
  always @(negedge mclk_in) begin
    if (rd_seen === 1'h1) begin
      ent = exp_q.pop_front();
      check(sfr_rdata_out & ent[15:8], ent[7:0]);
    end
  end

  // Watchdog sized well above the roughly 2500 cycles the tests need.
  initial begin
    repeat (20000) @(posedge mclk_in);
    err_total++;
    give_verdict();
  end

  initial begin
    void'($urandom(1564));
    cyc(16);
    sys_rst_in = 1'h0;
    rd_reg(CFG_ADDR, 8'hff, CFG_RESET);
    rd_reg(8'h55, 8'hff, RD_ZERO);
    wr_reg(CFG_ADDR, 8'hff);
    rd_reg(CFG_ADDR, 8'hff, 8'h77);
    $display("register test done");
    // Master role in all four clock modes against a prompt far-end slave.
    for (int m = 0; m < 4; m++) begin
      pol = m[0];
      pha = m[1];
      txb = 8'($urandom);
      fb = 8'($urandom);
      wr_reg(CFG_ADDR, {2'h1, pha, pol, 4'h0});
      cyc(4);
      check({7'h00, sck_out}, {7'h00, pol});
      check({6'h00, sck_oe_out, mosi_oe_out}, 8'h03);
      far_u.arm(pol, pha, 1'h0, fb);
      wr_reg(DATA_ADDR, txb);
      cyc(10);
      rd_reg(CFG_ADDR, 8'hc3, 8'hc3);
      cyc(80);
      rd_reg(CFG_ADDR, 8'h80, 8'h00);
      rd_reg(DATA_ADDR, 8'hff, fb);
      check(far_u.rx_q, txb);
    end
    // A disabled port must let go of every pin it drives.
    spi_enable_in = 1'h0;
    cyc(2);
    check({5'h00, sck_oe_out, mosi_oe_out, miso_oe_out}, 8'h00);
    spi_enable_in = 1'h1;
    $display("master modes done");
    // Receive queue: one byte more than its depth, then drain in order.
    wr_reg(CFG_ADDR, 8'h40);
    cyc(4);
    for (int i = 0; i < 17; i++) begin
      fill[i] = 8'($urandom);
      far_u.arm(1'h0, 1'h0, 1'h0, fill[i]);
      wr_reg(DATA_ADDR, 8'($urandom));
      cyc(80);
    end
    for (int i = 0; i < 17; i++) rd_reg(DATA_ADDR, 8'hff, fill[i]);
    $display("queue fill done");
    // Slave role in all four clock modes with the far end as bus master.
    for (int m = 0; m < 4; m++) begin
      pol = m[0];
      pha = m[1];
      txb = 8'($urandom);
      fb = 8'($urandom);
      wr_reg(CFG_ADDR, {2'h0, pha, pol, 4'h0});
      far_u.arm(pol, pha, 1'h1, fb);
      cyc(4);
      wr_reg(DATA_ADDR, txb);
      fork
        far_u.xfer();
        begin
          cyc(60);
          rd_reg(CFG_ADDR, 8'h8e, 8'h88);
          check({7'h00, miso_oe_out}, 8'h01);
        end
      join
      cyc(8);
      rd_reg(CFG_ADDR, 8'h0d, 8'h04);
      rd_reg(DATA_ADDR, 8'hff, fb);
      rd_reg(CFG_ADDR, 8'h8f, 8'h07);
      check(far_u.rx_q, txb);
    end
    $display("slave modes done");
    give_verdict();
  end
endmodule
